// ==== hdl/bct_pkg.sv ====
// Constants and types of the barcode transfer handshake block.
// Assumes one 50 MHz clock and a plain register port with 16-bit data.
package bct_pkg;

  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 16;
  localparam int FIELD_BYTES = 16;
  localparam int IDX_W       = 4;
  localparam int LEN_W       = 5;

  localparam logic [LEN_W-1:0] FIELD_LEN = 5'h10;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ACK       = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_UPD       = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_STAT      = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_LEN       = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FIELD     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FIELD_END = 8'h20;

  // Control word fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_HS_BIT   = 1;
  localparam int CTRL_FRAG_BIT = 2;

  // Reset values and update counter range
  localparam logic [2:0]        CTRL_RST  = 3'h0;
  localparam logic [DATA_W-1:0] CNT_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_FIRST = 16'h0001;
  localparam logic [DATA_W-1:0] CNT_MAX   = 16'hFFFF;

  typedef enum logic [1:0] {
    MODE_BASIC = 2'h0,
    MODE_HS    = 2'h1,
    MODE_FRAG  = 2'h3
  } bct_mode_e;

  // Gray along collect, drain, hold
  typedef enum logic [1:0] {
    ST_COLLECT = 2'h0,
    ST_DRAIN   = 2'h1,
    ST_HOLD    = 2'h3
  } bct_state_e;

  // Status flags, overflow in bit 0
  typedef struct packed {
    logic last;
    logic middle;
    logic first;
    logic frag;
    logic ovf;
  } bct_flag_s;

  localparam bct_flag_s FLAG_RST = 5'h00;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } bct_byte_s;

endpackage

// ==== hdl/bct_top.sv ====
// Barcode transfer block: collects scanner bytes and publishes them in an
// input data field with basic, handshake or fragmented transfer.
// Assumes synchronous inputs on CLK_SYS and a master that never waits.
`timescale 1ns/10ps
`default_nettype none

module bct_top (
  // Clock and reset
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESETN,
  // Register port
  input  wire logic [bct_pkg::ADDR_W-1:0]  REG_ADDR,
  input  wire logic [bct_pkg::DATA_W-1:0]  REG_WDATA,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  output logic      [bct_pkg::DATA_W-1:0]  REG_RDATA,
  // Scanner side
  input  wire bct_pkg::bct_byte_s          SCAN_IN,
  output logic                             SCAN_READY,
  output logic                             SCAN_ENABLE,
  input  wire logic                        SCAN_TRIGGER,
  // Link events
  input  wire logic                        LINK_RESET
);
  import bct_pkg::*;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [DATA_W-1:0] cnt_next(input logic [DATA_W-1:0] c);
    cnt_next = (c == CNT_MAX) ? CNT_FIRST : c + CNT_FIRST;
  endfunction

  function automatic bct_mode_e mode_decode(input logic hs, input logic frag);
    if (!hs) begin
      mode_decode = MODE_BASIC;
    end else if (frag) begin
      mode_decode = MODE_FRAG;
    end else begin
      mode_decode = MODE_HS;
    end
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [2:0]        ctrl_ff;
  logic [DATA_W-1:0] ack_ff;
  logic [DATA_W-1:0] upd_ff;
  logic              en_q_ff;
  logic              ack_nz_q_ff;
  bct_mode_e         mode_ff;
  bct_state_e        st_ff;
  bct_state_e        nxt_st;
  logic [7:0]        stage_mem_ff [FIELD_BYTES];
  logic [LEN_W-1:0]  stage_len_ff;
  logic              stage_ovf_ff;
  logic              stage_more_ff;
  logic              frag_on_ff;
  logic [7:0]        field_mem_ff [FIELD_BYTES];
  logic [LEN_W-1:0]  field_len_ff;
  bct_flag_s         flag_ff;
  logic              trig_ff;
  logic              trig_hold_ff;
  logic              ready_ff;
  logic              scan_en_ff;
  logic [DATA_W-1:0] rdata_ff;

  logic en;
  logic en_rise;
  logic en_fall;
  logic hs_on;
  logic frag_mode;
  logic acked;
  logic err;
  logic accept;
  logic got_last;
  logic stage_full;
  logic publish;
  logic fld_hit;
  logic [IDX_W-1:0] fld_idx;

  assign en         = ctrl_ff[CTRL_EN_BIT];
  assign en_rise    = en & ~en_q_ff;
  assign en_fall    = ~en & en_q_ff;
  assign hs_on      = (mode_ff != MODE_BASIC);
  assign frag_mode  = (mode_ff == MODE_FRAG);
  // Acknowledge counter only matters with handshake on
  assign acked      = ~hs_on | (ack_ff == upd_ff);
  // Link reset, disable, or ack dropping to zero
  // Only the drop counts: the first load from a zero pair leaves ack at zero
  assign err        = LINK_RESET | en_fall | (hs_on & (ack_ff == CNT_RST) & ack_nz_q_ff);
  assign accept     = SCAN_IN.valid & ready_ff;
  assign got_last   = accept & SCAN_IN.last;
  assign stage_full = (stage_len_ff == FIELD_LEN);
  // Gated by enable and acknowledge; zero pair resumes pending data
  assign publish    = (st_ff == ST_HOLD) & en & acked & ~err;
  assign fld_hit    = (REG_ADDR >= OFS_FIELD) && (REG_ADDR < OFS_FIELD_END);
  assign fld_idx    = IDX_W'(REG_ADDR - OFS_FIELD);

  // ------------------------------------------------------------
  // Control and acknowledge registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ctrl_ff <= CTRL_RST;
      ack_ff  <= CNT_RST;
    end else if (REG_WR) begin
      // Bits 0..2 of the control word
      if (REG_ADDR == OFS_CTRL) begin
        ctrl_ff <= REG_WDATA[2:0];
      end
      if (REG_ADDR == OFS_ACK) begin
        ack_ff <= REG_WDATA;
      end
    end
  end

  // Mode only follows the select bits at the enable edge
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      en_q_ff     <= 1'b0;
      ack_nz_q_ff <= 1'b0;
      mode_ff     <= MODE_BASIC;
    end else begin
      en_q_ff     <= en;
      ack_nz_q_ff <= (ack_ff != CNT_RST);
      if (en_rise) begin
        mode_ff <= mode_decode(ctrl_ff[CTRL_HS_BIT], ctrl_ff[CTRL_FRAG_BIT]);
      end
    end
  end

  // ------------------------------------------------------------
  // Stage collection
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_COLLECT: begin
        if (got_last) begin
          nxt_st = ST_HOLD;
        end else if (accept && stage_len_ff == FIELD_LEN - 5'h01) begin
          // Fragment mode ships a full block; else drop the tail
          nxt_st = frag_mode ? ST_HOLD : ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (got_last) begin
          nxt_st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (publish) begin
          nxt_st = ST_COLLECT;
        end
      end
      default: nxt_st = ST_COLLECT;
    endcase
  end

  // Held stage survives a disable and waits for re-enable
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      st_ff         <= ST_COLLECT;
      stage_len_ff  <= '0;
      stage_ovf_ff  <= 1'b0;
      stage_more_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (publish) begin
        stage_len_ff  <= '0;
        stage_ovf_ff  <= 1'b0;
        stage_more_ff <= 1'b0;
      end else if (accept && st_ff == ST_COLLECT && !stage_full) begin
        stage_len_ff  <= stage_len_ff + 5'h01;
        stage_more_ff <= (nxt_st == ST_HOLD) & ~SCAN_IN.last;
      end else if (accept && st_ff == ST_DRAIN) begin
        stage_ovf_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (accept && st_ff == ST_COLLECT && !stage_full) begin
      stage_mem_ff[stage_len_ff[IDX_W-1:0]] <= SCAN_IN.data;
    end
  end

  // Stall the scanner while a block waits; output straight from a flop
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_st != ST_HOLD);
    end
  end

  // Scanning disabled while the controller is busy
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      scan_en_ff <= 1'b0;
    end else begin
      scan_en_ff <= en & acked & ~publish & ~err;
    end
  end

  // ------------------------------------------------------------
  // Publication into the input data field
  // ------------------------------------------------------------
  // Basic mode overwrites at once each block is held while enabled, without waiting for acknowledge
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      field_mem_ff <= '{default: 8'h00};
    end else if (publish) begin
      field_mem_ff <= stage_mem_ff;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      field_len_ff <= '0;
      flag_ff      <= FLAG_RST;
      frag_on_ff   <= 1'b0;
    end else if (publish) begin
      // Full length on first and middle, remainder on last
      field_len_ff   <= stage_len_ff;
      flag_ff.ovf    <= stage_ovf_ff;
      // Fitting barcode leaves the fragmented flag clear
      flag_ff.frag   <= stage_more_ff | frag_on_ff;
      flag_ff.first  <= stage_more_ff & ~frag_on_ff;
      flag_ff.middle <= stage_more_ff & frag_on_ff;
      flag_ff.last   <= ~stage_more_ff & frag_on_ff;
      frag_on_ff     <= stage_more_ff;
    end
  end

  // Zero on error, else step 1..65535 on each load
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      upd_ff <= CNT_RST;
    end else if (err) begin
      upd_ff <= CNT_RST;
    end else if (publish) begin
      upd_ff <= cnt_next(upd_ff);
    end
  end

  // ------------------------------------------------------------
  // Trigger state
  // ------------------------------------------------------------
  // A read forces the bit low until the trigger is let go
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      trig_hold_ff <= 1'b0;
      trig_ff      <= 1'b0;
    end else begin
      if (got_last) begin
        trig_hold_ff <= 1'b1;
      end else if (!SCAN_TRIGGER) begin
        trig_hold_ff <= 1'b0;
      end
      trig_ff <= SCAN_TRIGGER & ~trig_hold_ff & ~got_last;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Data stand one cycle only, zero otherwise
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN || !REG_RD) begin
      rdata_ff <= '0;
    end else if (fld_hit) begin
      rdata_ff <= {8'h00, field_mem_ff[fld_idx]};
    end else begin
      case (REG_ADDR)
        OFS_CTRL: rdata_ff <= {13'h0000, ctrl_ff};
        OFS_ACK:  rdata_ff <= ack_ff;
        OFS_UPD:  rdata_ff <= upd_ff;
        OFS_STAT: rdata_ff <= {8'h00, mode_ff, trig_ff, flag_ff};
        OFS_LEN:  rdata_ff <= {11'h000, field_len_ff};
        default:  rdata_ff <= '0;
      endcase
    end
  end

  assign REG_RDATA   = rdata_ff;
  assign SCAN_READY  = ready_ff;
  assign SCAN_ENABLE = scan_en_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_basic_overwrite: assert property (
    (mode_ff == MODE_BASIC && st_ff == ST_HOLD && en && !err) |=> (upd_ff != CNT_RST && st_ff != ST_HOLD))
    else $error("basic mode did not publish at once");

  a_hs_scan_off: assert property (
    (hs_on && ack_ff != upd_ff) |=> !SCAN_ENABLE)
    else $error("scanning enabled while controller busy");

  a_mode_stable: assert property (
    !en_rise |=> $stable(mode_ff))
    else $error("mode changed outside enable edge");

  a_mode_invalid: assert property (
    (en_rise && !ctrl_ff[CTRL_HS_BIT]) |=> mode_ff == MODE_BASIC)
    else $error("invalid select did not give basic");

  a_upd_step: assert property (
    ($changed(upd_ff) && upd_ff != CNT_RST) |->
      upd_ff == (($past(upd_ff) == CNT_MAX) ? CNT_FIRST : $past(upd_ff) + CNT_FIRST))
    else $error("update counter step wrong");

  a_trunc_flag: assert property (
    (publish && !frag_mode && stage_ovf_ff) |=> (flag_ff.ovf && field_len_ff == FIELD_LEN))
    else $error("truncation not flagged");

  a_hs_no_overwrite: assert property (
    (hs_on && ack_ff != upd_ff) |=> (upd_ff == $past(upd_ff) || upd_ff == CNT_RST))
    else $error("field overwritten before acknowledge");

  a_link_err_zero: assert property (
    LINK_RESET |=> upd_ff == CNT_RST)
    else $error("error did not zero update counter");

  a_ack_zero_resync: assert property (
    (hs_on && ack_ff == CNT_RST && $changed(ack_ff)) |=> upd_ff == CNT_RST)
    else $error("ack zero did not zero update counter");

  a_first_frag: assert property (
    (publish && stage_more_ff && !frag_on_ff) |=>
      (flag_ff.frag && flag_ff.first && !flag_ff.last && field_len_ff == FIELD_LEN))
    else $error("first fragment flags wrong");

  a_last_frag: assert property (
    (publish && !stage_more_ff && frag_on_ff) ##1 1'b1 |-> (flag_ff.frag && flag_ff.last && !flag_ff.middle))
    else $error("last fragment flags wrong");

  a_trig_clear: assert property (
    got_last |=> !trig_ff)
    else $error("trigger bit not cleared on read");

  c_basic_pub: cover property (mode_ff == MODE_BASIC && publish);
  c_frag_middle: cover property (publish && stage_more_ff && frag_on_ff);
  c_resync: cover property (hs_on && upd_ff != CNT_RST ##1 ack_ff == CNT_RST ##[1:20] publish);
  c_overflow: cover property (publish && stage_ovf_ff);

endmodule

`default_nettype wire

// ==== tb/bct_ctl_model.sv ====
// Controller model: bus master on the register port of the transfer block.
// Assumes each task is entered just after a rising edge of clk_sys.
`timescale 1ns/10ps
`default_nettype none

module bct_ctl_model (
  // Clock
  input  wire logic                        clk_sys,
  // Register port
  output var  logic [bct_pkg::ADDR_W-1:0]  reg_addr,
  output var  logic [bct_pkg::DATA_W-1:0]  reg_wdata,
  output var  logic                        reg_wr,
  output var  logic                        reg_rd,
  input  wire logic [bct_pkg::DATA_W-1:0]  reg_rdata
);
  import bct_pkg::*;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
  end

  // Idle edge after a write, so a strobe is never set twice at one edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk_sys);
    reg_wr    <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys);
    reg_rd   <= 1'h0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic set_ctrl(input logic [2:0] c);
    wr(OFS_CTRL, {13'h0000, c});
  endtask

  // Copy the update count back once the data is consumed
  task automatic ack_latest();
    logic [DATA_W-1:0] u;
    rd(OFS_UPD, u);
    wr(OFS_ACK, u);
  endtask

  task automatic resync();
    wr(OFS_ACK, 16'h0000);
  endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench of the barcode transfer block.
// Assumes bct_ctl_model as controller; the bench plays the scanner.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import bct_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] exp;
  } bct_row_s;

  localparam int TIMEOUT_CYC = 20000;

  logic              clk_sys;
  logic              resetn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  bct_byte_s         scan_in;
  logic              scan_ready;
  logic              scan_enable;
  logic              scan_trigger;
  logic              link_reset;
  int                failures;
  int                samples_checked;
  int                cycles;

  // Reset values, unmapped 0x05 included
  bct_row_s rows [7] = '{'{8'h00, 16'h0000}, '{8'h01, 16'h0000}, '{8'h02, 16'h0000},
    '{8'h03, 16'h0000}, '{8'h04, 16'h0000}, '{8'h05, 16'h0000}, '{8'h10, 16'h0000}};
  logic [DATA_W-1:0] frag_stat [3] = '{16'h00C6, 16'h00CA, 16'h00D2};

  bct_top dut_u (
    .CLK_SYS      (clk_sys),
    .RESETN       (resetn),
    .REG_ADDR     (reg_addr),
    .REG_WDATA    (reg_wdata),
    .REG_WR       (reg_wr),
    .REG_RD       (reg_rd),
    .REG_RDATA    (reg_rdata),
    .SCAN_IN      (scan_in),
    .SCAN_READY   (scan_ready),
    .SCAN_ENABLE  (scan_enable),
    .SCAN_TRIGGER (scan_trigger),
    .LINK_RESET   (link_reset)
  );

  bct_ctl_model ctl_u (
    .clk_sys   (clk_sys),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  initial begin
    clk_sys = 1'h0;
  end
  always #10 clk_sys = ~clk_sys;

  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYC) begin
      failures++;
      final_report();
    end
  end

  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] v;
    ctl_u.rd(a, v);
    cmp(v, e);
  endtask

  task automatic chk_pin(input logic got, input logic e);
    cmp({15'h0000, got}, {15'h0000, e});
  endtask

  task automatic chk_mode(input bct_mode_e e);
    logic [DATA_W-1:0] v;
    ctl_u.rd(OFS_STAT, v);
    cmp({14'h0000, v[7:6]}, {14'h0000, e});
  endtask

  // Polls the update count; a hang is caught by the cycle ceiling
  task automatic wait_upd(input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] v;
    do ctl_u.rd(OFS_UPD, v); while (v !== e);
    cmp(v, e);
  endtask

  task automatic send(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      scan_in <= '{valid: 1'h1, last: (i == n - 1), data: base + 8'(i)};
      do @(posedge clk_sys); while (scan_ready !== 1'h1);
    end
    scan_in <= '0;
  endtask

  initial begin
    scan_in         = '0;
    scan_trigger    = 1'h0;
    link_reset      = 1'h0;
    resetn          = 1'h0;
    failures        = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    foreach (rows[i]) chk_reg(rows[i].addr, rows[i].exp);
    // ----------------------------------------
    // Basic mode, trigger, overflow
    // ----------------------------------------
    ctl_u.set_ctrl(3'h1);
    scan_trigger <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chk_reg(OFS_STAT, 16'h0020);
    send(3, 8'h10);
    wait_upd(16'h0001);
    chk_reg(OFS_STAT, 16'h0000);
    chk_reg(OFS_LEN, 16'h0003);
    chk_reg(OFS_FIELD + 8'h02, 16'h0012);
    scan_trigger <= 1'h0;
    ctl_u.wr(OFS_ACK, 16'h0005);
    send(20, 8'h20);
    wait_upd(16'h0002);
    chk_reg(OFS_STAT, 16'h0001);
    chk_reg(OFS_LEN, 16'h0010);
    chk_reg(OFS_FIELD + 8'h0F, 16'h002F);
    link_reset <= 1'h1;
    @(posedge clk_sys);
    link_reset <= 1'h0;
    chk_reg(OFS_UPD, 16'h0000);
    // ----------------------------------------
    // Mode latch and handshake
    // ----------------------------------------
    ctl_u.set_ctrl(3'h0);
    ctl_u.set_ctrl(3'h5);
    chk_mode(MODE_BASIC);
    ctl_u.set_ctrl(3'h0);
    ctl_u.resync();
    ctl_u.set_ctrl(3'h3);
    ctl_u.set_ctrl(3'h7);
    chk_mode(MODE_HS);
    send(2, 8'h30);
    wait_upd(16'h0001);
    chk_pin(scan_enable, 1'h0);
    send(2, 8'h38);
    repeat (20) @(posedge clk_sys);
    chk_pin(scan_ready, 1'h0);
    chk_reg(OFS_UPD, 16'h0001);
    chk_reg(OFS_FIELD, 16'h0030);
    ctl_u.set_ctrl(3'h0);
    chk_reg(OFS_UPD, 16'h0000);
    ctl_u.set_ctrl(3'h3);
    wait_upd(16'h0001);
    chk_reg(OFS_FIELD, 16'h0038);
    ctl_u.ack_latest();
    // Enable flop follows the acknowledge one edge later
    @(posedge clk_sys);
    chk_pin(scan_enable, 1'h1);
    ctl_u.resync();
    chk_reg(OFS_UPD, 16'h0000);
    send(1, 8'h70);
    wait_upd(16'h0001);
    // ----------------------------------------
    // Fragmented: 36 bytes as 16 + 16 + 4
    // ----------------------------------------
    ctl_u.set_ctrl(3'h0);
    ctl_u.resync();
    ctl_u.set_ctrl(3'h7);
    chk_mode(MODE_FRAG);
    fork
      send(36, 8'h40);
      begin
        for (int b = 0; b < 3; b++) begin
          wait_upd(16'(b + 1));
          chk_reg(OFS_STAT, frag_stat[b]);
          chk_reg(OFS_LEN, (b == 2) ? 16'h0004 : 16'h0010);
          chk_reg(OFS_FIELD, {8'h00, 8'h40 + 8'(16 * b)});
          chk_reg(OFS_UPD, 16'(b + 1));
          ctl_u.ack_latest();
        end
      end
    join
    send(5, 8'h80);
    wait_upd(16'h0004);
    chk_reg(OFS_STAT, 16'h00C0);
    chk_reg(OFS_LEN, 16'h0005);
    // ----------------------------------------
    // Reset in mid-run with a block still held
    // ----------------------------------------
    send(3, 8'h90);
    resetn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk_pin(scan_ready, 1'h0);
    resetn <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chk_pin(scan_ready, 1'h1);
    foreach (rows[i]) chk_reg(rows[i].addr, rows[i].exp);
    final_report();
  end
endmodule

`default_nettype wire
